// ==== logic/ucrd_addr_decode.sv ====
`timescale 1ns/1ps
`include "ucrd_params.svh"

module ucrd_addr_decode (
  input wire logic [2:0] regAddr,
  input wire logic [7:0] lineControl,
  input wire logic enhEnable,
  output ucrd_pkg::ucrd_sel_t regSel
);
  import ucrd_pkg::*;

  logic keyPage;
  logic divAccess;

  assign keyPage = (lineControl == `UCRD_KEY_ENH);
  assign divAccess = lineControl[`UCRD_LCR_DIVACC];

  always_comb begin
    regSel = UCRD_SEL_NONE;
    case (regAddr)
      `UCRD_ADDR_RXTX: begin
        // The key value also sets the divisor-access bit, so it must be excluded here.
        if (!divAccess) regSel = UCRD_SEL_RXTX;
        else if (!keyPage) regSel = UCRD_SEL_DLL;
        else regSel = UCRD_SEL_NONE;
      end
      `UCRD_ADDR_IER: begin
        if (!divAccess) regSel = UCRD_SEL_IER;
        else if (!keyPage) regSel = UCRD_SEL_DLM;
        else regSel = UCRD_SEL_NONE;
      end
      `UCRD_ADDR_ISRFCR: begin
        if (!divAccess) regSel = UCRD_SEL_ISRFCR;
        else if (keyPage) regSel = UCRD_SEL_EFR;
        else if (enhEnable) regSel = UCRD_SEL_DLD;
        else regSel = UCRD_SEL_NONE;
      end
      `UCRD_ADDR_LCR: regSel = UCRD_SEL_LCR;
      `UCRD_ADDR_MCR: regSel = keyPage ? UCRD_SEL_XON1 : UCRD_SEL_MCR;
      `UCRD_ADDR_LSR: regSel = keyPage ? UCRD_SEL_XON2 : UCRD_SEL_LSR;
      `UCRD_ADDR_MSR: regSel = keyPage ? UCRD_SEL_XOFF1 : UCRD_SEL_MSR;
      `UCRD_ADDR_SPR: regSel = keyPage ? UCRD_SEL_XOFF2 : UCRD_SEL_SPR;
      default: regSel = UCRD_SEL_NONE;
    endcase
  end

endmodule : ucrd_addr_decode

// ==== logic/ucrd_channel_regs.sv ====
// What this block does
// - Private register set decoded per selected channel.
// - Address 0: receive read, transmit write.
// - Divisor access: addresses 0,1 are divisor bytes.
// - Divisor access 2: fraction register, enhanced only.
// - Normal 1: interrupt enable; 2: status/FIFO control.
// - 3 line control; 4-7 modem, status, scratch.
// - Key value: enhanced register and flow characters.
// - Status select low: read FIFO ready byte.
// - Enhanced bits work only with enhanced bit.
// - Modem bits gate interrupt, drive RTS/DTR.
// - Modem bit 4: internal loopback, TX marks.
`timescale 1ns/1ps
`include "ucrd_params.svh"

module ucrd_channel_regs #(
  parameter int NUM_CH = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic chanSel,
  input wire logic [2:0] regAddr,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire logic fifoStatusSelN,
  input wire logic [NUM_CH-1:0] rxReadyFlags,
  input wire logic [NUM_CH-1:0] txReadyFlags,
  input wire logic [7:0] rxHoldingData,
  output logic rxPop,
  output logic [7:0] txHoldingData,
  output logic txLoad,
  input wire logic [7:0] intStatusIn,
  output logic intStatusRead,
  input wire logic [7:0] lineStatusIn,
  output logic lineStatusRead,
  input wire logic [7:0] modemStatusIn,
  output logic modemStatusRead,
  output logic [7:0] fifoControl,
  output logic fifoControlWrite,
  output logic [7:0] divisorLow,
  output logic [7:0] divisorHigh,
  output logic [7:0] divisorFraction,
  output logic [7:0] intEnable,
  output logic [7:0] lineControl,
  output logic [7:0] modemControl,
  output logic [7:0] scratchByte,
  output logic [7:0] enhancedFeatures,
  output logic [7:0] resumeCharOne,
  output logic [7:0] resumeCharTwo,
  output logic [7:0] pauseCharOne,
  output logic [7:0] pauseCharTwo,
  input wire logic intRaw,
  output logic intOut,
  output logic rtsOutN,
  output logic dtrOutN,
  output logic spareOutOneN,
  input wire logic txShiftOut,
  input wire logic rxPin,
  output logic txPin,
  output logic rxShiftIn
);
  import ucrd_pkg::*;

  // Keeps the enhanced bits of a field only while enhanced functions are on.
  function automatic logic [7:0] ucrd_enh_keep(input logic [7:0] mask, input logic enh);
    return enh ? 8'hFF : ~mask;
  endfunction : ucrd_enh_keep

  // Write merge that leaves enhanced bits untouched while they are locked.
  function automatic logic [7:0] ucrd_wr_merge(input logic [7:0] oldVal, input logic [7:0] newVal,
                                                input logic [7:0] mask, input logic enh);
    return enh ? newVal : ((newVal & ~mask) | (oldVal & mask));
  endfunction : ucrd_wr_merge

  logic [7:0] dll_r;
  logic [7:0] dlm_r;
  logic [7:0] dld_r;
  logic [7:0] ier_r;
  logic [7:0] fcr_r;
  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] spr_r;
  logic [7:0] efr_r;
  logic [7:0] xon1_r;
  logic [7:0] xon2_r;
  logic [7:0] xoff1_r;
  logic [7:0] xoff2_r;
  logic [7:0] thr_r;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdValid_r;
  logic txLoad_r;
  logic fcrWr_r;
  logic intOut_r;
  logic rtsN_r;
  logic dtrN_r;
  logic spareN_r;
  logic txPin_r;
  logic rxShift_r;
  logic enh;
  logic loopOn;
  logic regWr;
  logic regRd;
  logic statusRd;
  logic [7:0] fifoStatusByte;
  ucrd_sel_t regSel;

  assign enh = efr_r[`UCRD_EFR_ENH];
  assign loopOn = mcr_r[`UCRD_MCR_LOOP];
  assign regWr = wrStrobe & chanSel;
  assign regRd = rdStrobe & chanSel & fifoStatusSelN;
  assign statusRd = rdStrobe & ~fifoStatusSelN;

  ucrd_addr_decode u_decode (
    .regAddr(regAddr),
    .lineControl(lcr_r),
    .enhEnable(enh),
    .regSel(regSel)
  );

  ucrd_fifo_status #(
    .NUM_CH(NUM_CH)
  ) u_fifo_ready_flags (
    .rxReadyFlags(rxReadyFlags),
    .txReadyFlags(txReadyFlags),
    .statusByte(fifoStatusByte)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dll_r <= `UCRD_RST_BYTE;
      dlm_r <= `UCRD_RST_BYTE;
      dld_r <= `UCRD_RST_BYTE;
    end else if (regWr) begin
      if (regSel == UCRD_SEL_DLL) dll_r <= wrData;
      if (regSel == UCRD_SEL_DLM) dlm_r <= wrData;
      if (regSel == UCRD_SEL_DLD) dld_r <= wrData & `UCRD_DLD_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ier_r <= `UCRD_RST_BYTE;
      lcr_r <= `UCRD_RST_BYTE;
      mcr_r <= `UCRD_RST_BYTE;
      spr_r <= `UCRD_RST_BYTE;
    end else if (regWr) begin
      if (regSel == UCRD_SEL_IER) ier_r <= ucrd_wr_merge(ier_r, wrData, `UCRD_IER_ENH_MASK, enh);
      if (regSel == UCRD_SEL_LCR) lcr_r <= wrData;
      if (regSel == UCRD_SEL_MCR) mcr_r <= ucrd_wr_merge(mcr_r, wrData, `UCRD_MCR_ENH_MASK, enh);
      if (regSel == UCRD_SEL_SPR) spr_r <= wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      efr_r <= `UCRD_RST_BYTE;
      xon1_r <= `UCRD_RST_BYTE;
      xon2_r <= `UCRD_RST_BYTE;
      xoff1_r <= `UCRD_RST_BYTE;
      xoff2_r <= `UCRD_RST_BYTE;
    end else if (regWr) begin
      if (regSel == UCRD_SEL_EFR) efr_r <= wrData;
      if (regSel == UCRD_SEL_XON1) xon1_r <= wrData;
      if (regSel == UCRD_SEL_XON2) xon2_r <= wrData;
      if (regSel == UCRD_SEL_XOFF1) xoff1_r <= wrData;
      if (regSel == UCRD_SEL_XOFF2) xoff2_r <= wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      thr_r <= `UCRD_RST_BYTE;
      fcr_r <= `UCRD_RST_BYTE;
      txLoad_r <= 1'b0;
      fcrWr_r <= 1'b0;
    end else begin
      txLoad_r <= regWr && (regSel == UCRD_SEL_RXTX);
      fcrWr_r <= regWr && (regSel == UCRD_SEL_ISRFCR);
      if (regWr && (regSel == UCRD_SEL_RXTX)) thr_r <= wrData;
      // The FIFO control register is write-only, so locked bits are simply dropped.
      if (regWr && (regSel == UCRD_SEL_ISRFCR)) fcr_r <= wrData & ucrd_enh_keep(`UCRD_FCR_ENH_MASK, enh);
    end
  end

  always_comb begin
    rdData_nxt = `UCRD_RST_BYTE;
    case (regSel)
      UCRD_SEL_RXTX: rdData_nxt = rxHoldingData;
      UCRD_SEL_DLL: rdData_nxt = dll_r;
      UCRD_SEL_DLM: rdData_nxt = dlm_r;
      UCRD_SEL_DLD: rdData_nxt = dld_r;
      UCRD_SEL_IER: rdData_nxt = ier_r & ucrd_enh_keep(`UCRD_IER_ENH_MASK, enh);
      UCRD_SEL_ISRFCR: rdData_nxt = intStatusIn & ucrd_enh_keep(`UCRD_ISR_ENH_MASK, enh);
      UCRD_SEL_LCR: rdData_nxt = lcr_r;
      UCRD_SEL_MCR: rdData_nxt = mcr_r & ucrd_enh_keep(`UCRD_MCR_ENH_MASK, enh);
      UCRD_SEL_LSR: rdData_nxt = lineStatusIn;
      UCRD_SEL_MSR: rdData_nxt = modemStatusIn;
      UCRD_SEL_SPR: rdData_nxt = spr_r;
      UCRD_SEL_EFR: rdData_nxt = efr_r;
      UCRD_SEL_XON1: rdData_nxt = xon1_r;
      UCRD_SEL_XON2: rdData_nxt = xon2_r;
      UCRD_SEL_XOFF1: rdData_nxt = xoff1_r;
      UCRD_SEL_XOFF2: rdData_nxt = xoff2_r;
      default: rdData_nxt = `UCRD_RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdData_r <= `UCRD_RST_BYTE;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regRd | statusRd;
      if (statusRd) rdData_r <= fifoStatusByte;
      else if (regRd) rdData_r <= rdData_nxt;
    end
  end

  // Read side effects fire in the strobe cycle so the data path can advance before the next access.
  assign rxPop = regRd && (regSel == UCRD_SEL_RXTX);
  assign intStatusRead = regRd && (regSel == UCRD_SEL_ISRFCR);
  assign lineStatusRead = regRd && (regSel == UCRD_SEL_LSR);
  assign modemStatusRead = regRd && (regSel == UCRD_SEL_MSR);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      intOut_r <= 1'b0;
      rtsN_r <= 1'b1;
      dtrN_r <= 1'b1;
      spareN_r <= 1'b1;
      txPin_r <= 1'b1;
      rxShift_r <= 1'b1;
    end else begin
      intOut_r <= intRaw & mcr_r[`UCRD_MCR_GATE];
      rtsN_r <= loopOn | ~mcr_r[`UCRD_MCR_RTS];
      dtrN_r <= loopOn | ~mcr_r[`UCRD_MCR_DTR];
      spareN_r <= ~mcr_r[`UCRD_MCR_SPARE];
      txPin_r <= loopOn | txShiftOut;
      rxShift_r <= loopOn ? txShiftOut : rxPin;
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign txHoldingData = thr_r;
  assign txLoad = txLoad_r;
  assign fifoControl = fcr_r & ucrd_enh_keep(`UCRD_FCR_ENH_MASK, enh);
  assign fifoControlWrite = fcrWr_r;
  assign divisorLow = dll_r;
  assign divisorHigh = dlm_r;
  assign divisorFraction = dld_r;
  assign intEnable = ier_r & ucrd_enh_keep(`UCRD_IER_ENH_MASK, enh);
  assign modemControl = mcr_r & ucrd_enh_keep(`UCRD_MCR_ENH_MASK, enh);
  assign lineControl = lcr_r;
  assign scratchByte = spr_r;
  assign enhancedFeatures = efr_r;
  assign resumeCharOne = xon1_r;
  assign resumeCharTwo = xon2_r;
  assign pauseCharOne = xoff1_r;
  assign pauseCharTwo = xoff2_r;
  assign intOut = intOut_r;
  assign rtsOutN = rtsN_r;
  assign dtrOutN = dtrN_r;
  assign spareOutOneN = spareN_r;
  assign txPin = txPin_r;
  assign rxShiftIn = rxShift_r;

  property p_unselected_write;
    @(posedge sys_clk) disable iff (srst)
      (wrStrobe && !chanSel) |=> ($stable(lcr_r) && $stable(spr_r) && !txLoad);
  endproperty
  a_unselected_write: assert property (p_unselected_write) else $error("Unselected write changed state");

  property p_rx_read;
    @(posedge sys_clk) disable iff (srst)
      (regRd && regAddr == `UCRD_ADDR_RXTX && !lcr_r[`UCRD_LCR_DIVACC])
        |-> rxPop ##1 (rdValid && rdData == $past(rxHoldingData));
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("Receive holding read wrong");

  property p_tx_load;
    @(posedge sys_clk) disable iff (srst)
      (regWr && regAddr == `UCRD_ADDR_RXTX && !lcr_r[`UCRD_LCR_DIVACC])
        |=> (txLoad && txHoldingData == $past(wrData)) ##1 !txLoad;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("Transmit holding load wrong");

  property p_div_low;
    @(posedge sys_clk) disable iff (srst)
      (regWr && regAddr == `UCRD_ADDR_RXTX && lcr_r[`UCRD_LCR_DIVACC] && lcr_r != `UCRD_KEY_ENH)
        |=> (divisorLow == $past(wrData) && !txLoad);
  endproperty
  a_div_low: assert property (p_div_low) else $error("Divisor low write lost");

  property p_frac_locked;
    @(posedge sys_clk) disable iff (srst)
      (regWr && regAddr == `UCRD_ADDR_ISRFCR && lcr_r[`UCRD_LCR_DIVACC] && lcr_r != `UCRD_KEY_ENH && !enh)
        |=> ($stable(dld_r) && !fifoControlWrite);
  endproperty
  a_frac_locked: assert property (p_frac_locked) else $error("Fraction written while locked");

  property p_fcr_write;
    @(posedge sys_clk) disable iff (srst)
      (regWr && regAddr == `UCRD_ADDR_ISRFCR && !lcr_r[`UCRD_LCR_DIVACC]) |=> fifoControlWrite;
  endproperty
  a_fcr_write: assert property (p_fcr_write) else $error("FIFO control pulse missing");

  property p_lcr_write;
    @(posedge sys_clk) disable iff (srst)
      (regWr && regAddr == `UCRD_ADDR_LCR) |=> (lineControl == $past(wrData));
  endproperty
  a_lcr_write: assert property (p_lcr_write) else $error("Line control write lost");

  property p_key_page;
    @(posedge sys_clk) disable iff (srst)
      (regWr && regAddr == `UCRD_ADDR_SPR && lcr_r == `UCRD_KEY_ENH)
        |=> (pauseCharTwo == $past(wrData) && $stable(spr_r));
  endproperty
  a_key_page: assert property (p_key_page) else $error("Pause character two write wrong");

  property p_fifo_ready_flags_read;
    @(posedge sys_clk) disable iff (srst)
      (rdStrobe && !fifoStatusSelN) |=> (rdValid && rdData == $past({rxReadyFlags, txReadyFlags}));
  endproperty
  a_fifo_ready_flags_read: assert property (p_fifo_ready_flags_read) else $error("FIFO status byte wrong");

  property p_enh_outputs;
    @(posedge sys_clk) disable iff (srst)
      !enh |-> (intEnable[7:4] == 4'h0 && modemControl[7:5] == 3'h0 && fifoControl[5:4] == 2'h0) or
               $rose(efr_r[`UCRD_EFR_ENH]) or $fell(efr_r[`UCRD_EFR_ENH]);
  endproperty
  a_enh_outputs: assert property (p_enh_outputs) else $error("Enhanced bit active while locked");

  property p_int_gate;
    @(posedge sys_clk) disable iff (srst)
      1'b1 |=> (intOut == ($past(intRaw) && $past(mcr_r[`UCRD_MCR_GATE])));
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("Interrupt gate wrong");

  property p_ier_read_locked;
    @(posedge sys_clk) disable iff (srst)
      (regRd && regAddr == `UCRD_ADDR_IER && !lcr_r[`UCRD_LCR_DIVACC] && !enh)
        |=> (rdData[7:4] == 4'h0 && rdData[3:0] == $past(ier_r[3:0]));
  endproperty
  a_ier_read_locked: assert property (p_ier_read_locked) else $error("Locked enable bits read nonzero");

  property p_loopback;
    @(posedge sys_clk) disable iff (srst)
      loopOn |=> (txPin && rtsOutN && dtrOutN && rxShiftIn == $past(txShiftOut));
  endproperty
  a_loopback: assert property (p_loopback) else $error("Loopback routing wrong");

endmodule : ucrd_channel_regs

// ==== logic/ucrd_fifo_status.sv ====
`timescale 1ns/1ps

module ucrd_fifo_status #(
  parameter int NUM_CH = 4
) (
  input wire logic [NUM_CH-1:0] rxReadyFlags,
  input wire logic [NUM_CH-1:0] txReadyFlags,
  output logic [2*NUM_CH-1:0] statusByte
);

  // Receive flags in the upper half, transmit flags in the lower, highest channel first.
  assign statusByte = {rxReadyFlags, txReadyFlags};

endmodule : ucrd_fifo_status

// ==== logic/ucrd_params.svh ====
`ifndef UCRD_PARAMS_SVH
`define UCRD_PARAMS_SVH

// Register addresses on the three-bit channel address.
`define UCRD_ADDR_RXTX 3'h0
`define UCRD_ADDR_IER 3'h1
`define UCRD_ADDR_ISRFCR 3'h2
`define UCRD_ADDR_LCR 3'h3
`define UCRD_ADDR_MCR 3'h4
`define UCRD_ADDR_LSR 3'h5
`define UCRD_ADDR_MSR 3'h6
`define UCRD_ADDR_SPR 3'h7

// Line control value that opens the enhanced register page.
`define UCRD_KEY_ENH 8'hBF

// Field positions.
`define UCRD_LCR_DIVACC 7
`define UCRD_EFR_ENH 4
`define UCRD_MCR_DTR 0
`define UCRD_MCR_RTS 1
`define UCRD_MCR_SPARE 2
`define UCRD_MCR_GATE 3
`define UCRD_MCR_LOOP 4

// Bits that only work while the enhanced-function bit is set.
`define UCRD_IER_ENH_MASK 8'hF0
`define UCRD_ISR_ENH_MASK 8'h30
`define UCRD_FCR_ENH_MASK 8'h30
`define UCRD_MCR_ENH_MASK 8'hE0
// Fraction bits 3-0, 8X bit 4, 4X bit 5; bits 7-6 reserved.
`define UCRD_DLD_MASK 8'h3F

// Reset values.
`define UCRD_RST_BYTE 8'h00

`endif

// ==== logic/ucrd_pkg.sv ====
package ucrd_pkg;

  typedef enum logic [4:0] {
    UCRD_SEL_NONE = 5'h00,
    UCRD_SEL_RXTX = 5'h01,
    UCRD_SEL_DLL = 5'h02,
    UCRD_SEL_DLM = 5'h03,
    UCRD_SEL_DLD = 5'h04,
    UCRD_SEL_IER = 5'h05,
    UCRD_SEL_ISRFCR = 5'h06,
    UCRD_SEL_LCR = 5'h07,
    UCRD_SEL_MCR = 5'h08,
    UCRD_SEL_LSR = 5'h09,
    UCRD_SEL_MSR = 5'h0A,
    UCRD_SEL_SPR = 5'h0B,
    UCRD_SEL_EFR = 5'h0C,
    UCRD_SEL_XON1 = 5'h0D,
    UCRD_SEL_XON2 = 5'h0E,
    UCRD_SEL_XOFF1 = 5'h0F,
    UCRD_SEL_XOFF2 = 5'h10
  } ucrd_sel_t;

endpackage : ucrd_pkg

// ==== testbench/uart_channel_register_decode_tb.sv ====
`timescale 1ns/1ps

module uart_channel_register_decode_tb;
  logic sys_clk, srst, chanSel, wrStrobe, rdStrobe, fifoStatusSelN, rdValid, rxPop, txLoad;
  logic intStatusRead, lineStatusRead, modemStatusRead, fifoControlWrite, intRaw, intOut;
  logic rtsOutN, dtrOutN, spareOutOneN, txShiftOut, rxPin, txPin, rxShiftIn;
  logic [2:0] regAddr;
  logic [3:0] rxReadyFlags, txReadyFlags;
  logic [7:0] wrData, rdData, rxHoldingData, txHoldingData, intStatusIn, lineStatusIn, modemStatusIn;
  logic [7:0] fifoControl, divisorLow, divisorHigh, divisorFraction, intEnable, lineControl, modemControl;
  logic [7:0] scratchByte, enhancedFeatures, resumeCharOne, resumeCharTwo, pauseCharOne, pauseCharTwo;
  int miscompares, testsRun, popCount, loadCount;

  ucrd_channel_regs #(.NUM_CH(4)) dut (.sys_clk, .srst, .chanSel, .regAddr, .wrStrobe, .rdStrobe, .wrData,
    .rdData, .rdValid, .fifoStatusSelN, .rxReadyFlags, .txReadyFlags, .rxHoldingData, .rxPop, .txHoldingData,
    .txLoad, .intStatusIn, .intStatusRead, .lineStatusIn, .lineStatusRead, .modemStatusIn, .modemStatusRead,
    .fifoControl, .fifoControlWrite, .divisorLow, .divisorHigh, .divisorFraction, .intEnable, .lineControl,
    .modemControl, .scratchByte, .enhancedFeatures, .resumeCharOne, .resumeCharTwo, .pauseCharOne,
    .pauseCharTwo, .intRaw, .intOut, .rtsOutN, .dtrOutN, .spareOutOneN, .txShiftOut, .rxPin, .txPin,
    .rxShiftIn);

  ucrd_host_model host (.sys_clk, .chanSel, .regAddr, .wrStrobe, .rdStrobe, .wrData, .fifoStatusSelN,
    .rdData, .rdValid);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulse counters catch both a missing and a doubled side effect.
  always @(posedge sys_clk) begin
    if (rxPop === 1'b1) popCount++;
    if (txLoad === 1'b1) loadCount++;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    host.access(1'b1, 1'b1, 1'b1, a, d, q, ok);
  endtask : wr

  task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic ok;
    host.access(1'b1, 1'b1, 1'b0, a, 8'h00, q, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %s expected answer seen none", what);
      conclude();
    end
    check(what, exp, q);
  endtask : rd

  task automatic testReset();
    check("lineControl", 8'h00, lineControl);
    check("pins", 8'h1F, {2'h0, intOut, rtsOutN, dtrOutN, spareOutOneN, txPin, rxShiftIn});
    rd("scratch", 3'h7, 8'h00);
    $display("testReset done");
  endtask : testReset

  task automatic testNormal();
    int n;
    rxHoldingData = 8'hA5;
    wr(3'h3, 8'h03);
    rd("lineControl", 3'h3, 8'h03);
    wr(3'h7, 8'h5A);
    rd("scratch", 3'h7, 8'h5A);
    n = popCount;
    rd("rx holding", 3'h0, 8'hA5);
    check("rxPop count", 8'h01, 8'(popCount - n));
    n = loadCount;
    wr(3'h0, 8'h3C);
    check("txHoldingData", 8'h3C, txHoldingData);
    wr(3'h1, 8'hFF);
    rd("intEnable locked", 3'h1, 8'h0F);
    check("txLoad count", 8'h01, 8'(loadCount - n));
    wr(3'h2, 8'hFF);
    check("fifoControl", 8'hCF, fifoControl);
    intStatusIn = 8'hFF;
    lineStatusIn = 8'h61;
    modemStatusIn = 8'hB2;
    rd("int status", 3'h2, 8'hCF);
    rd("line status", 3'h5, 8'h61);
    rd("modem status", 3'h6, 8'hB2);
    $display("testNormal done");
  endtask : testNormal

  task automatic testDivisor();
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    rd("divisor low", 3'h0, 8'h12);
    rd("divisor high", 3'h1, 8'h34);
    check("txHoldingData kept", 8'h3C, txHoldingData);
    wr(3'h2, 8'hFF);
    rd("fraction locked", 3'h2, 8'h00);
    rd("scratch", 3'h7, 8'h5A);
    $display("testDivisor done");
  endtask : testDivisor

  task automatic testEnhanced();
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(3'(i + 4), 8'(8'h21 + i));
    end
    for (int i = 0; i < 4; i++) begin
      rd("flow char", 3'(i + 4), 8'(8'h21 + i));
    end
    check("resumeCharOne", 8'h21, resumeCharOne);
    check("pauseCharTwo", 8'h24, pauseCharTwo);
    check("modemControl kept", 8'h00, modemControl);
    rd("key page addr 0", 3'h0, 8'h00);
    wr(3'h0, 8'h77);
    check("divisorLow kept", 8'h12, divisorLow);
    rd("enhanced", 3'h2, 8'h10);
    wr(3'h3, 8'h80);
    wr(3'h2, 8'hFF);
    rd("fraction", 3'h2, 8'h3F);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'hF5);
    rd("intEnable", 3'h1, 8'hF5);
    rd("int status", 3'h2, 8'hFF);
    $display("testEnhanced done");
  endtask : testEnhanced

  task automatic testModem();
    intRaw = 1'b1;
    txShiftOut = 1'b0;
    rxPin = 1'b1;
    wr(3'h4, 8'hEB);
    check("modemControl", 8'hEB, modemControl);
    // Pins sit behind a register stage of their own, so allow it to land.
    repeat (2) @(negedge sys_clk);
    check("pins", 8'h25, {2'h0, intOut, rtsOutN, dtrOutN, spareOutOneN, txPin, rxShiftIn});
    wr(3'h4, 8'hF4);
    repeat (2) @(negedge sys_clk);
    check("pins loop", 8'h1A, {2'h0, intOut, rtsOutN, dtrOutN, spareOutOneN, txPin, rxShiftIn});
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h03);
    rd("modem locked", 3'h4, 8'h14);
    check("intEnable locked", 8'h05, intEnable);
    $display("testModem done");
  endtask : testModem

  task automatic testStatus();
    logic [7:0] q;
    logic ok;
    rxReadyFlags = 4'h9;
    txReadyFlags = 4'h6;
    host.access(1'b0, 1'b0, 1'b0, 3'h5, 8'h00, q, ok);
    check("status answered", 8'h01, {7'h0, ok});
    check("ready flags", 8'h96, q);
    host.access(1'b0, 1'b1, 1'b1, 3'h7, 8'hEE, q, ok);
    rd("scratch unselected", 3'h7, 8'h5A);
    $display("testStatus done");
  endtask : testStatus

  initial begin
    srst = 1'b1;
    intRaw = 1'b0;
    txShiftOut = 1'b1;
    rxPin = 1'b1;
    rxReadyFlags = 4'h0;
    txReadyFlags = 4'h0;
    rxHoldingData = 8'h00;
    intStatusIn = 8'h00;
    lineStatusIn = 8'h00;
    modemStatusIn = 8'h00;
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    testReset();
    testNormal();
    testDivisor();
    testEnhanced();
    testModem();
    testStatus();
    conclude();
  end
endmodule : uart_channel_register_decode_tb

// ==== testbench/ucrd_host_model.sv ====
`timescale 1ns/1ps

module ucrd_host_model (
  input wire logic sys_clk,
  output logic chanSel,
  output logic [2:0] regAddr,
  output logic wrStrobe,
  output logic rdStrobe,
  output logic [7:0] wrData,
  output logic fifoStatusSelN,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  initial begin
    chanSel = 1'b0;
    regAddr = 3'h0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    wrData = 8'h00;
    fifoStatusSelN = 1'b1;
  end

  // One access: strobe for one cycle, then wait a bounded time for the answer.
  task automatic access(input logic sel, input logic fsel, input logic wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b1;
    q = 8'h00;
    @(negedge sys_clk);
    chanSel = sel;
    fifoStatusSelN = fsel;
    regAddr = a;
    wrData = d;
    wrStrobe = wr;
    rdStrobe = !wr;
    @(negedge sys_clk);
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    chanSel = 1'b0;
    fifoStatusSelN = 1'b1;
    // Released lines flip so that a stale value can never pass for a held one.
    regAddr = ~a;
    wrData = ~d;
    if (!wr && (sel || !fsel)) begin
      while (rdValid !== 1'b1 && n < 4) begin
        @(negedge sys_clk);
        n++;
      end
      ok = (rdValid === 1'b1);
      q = rdData;
    end
  endtask : access
endmodule : ucrd_host_model
